/* File: hub_cfg_pkg.sv */
// Constants and types for the port ownership register store and loader
`default_nettype none
package hub_cfg_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_OWNER_1_2 = 8'hF1;
  localparam logic [7:0] OFF_OWNER_3_4 = 8'hF2;
  localparam logic [7:0] OFF_OWNER_5_6 = 8'hF3;
  localparam logic [7:0] OFF_OWNER_7 = 8'hF4;
  localparam logic [7:0] OFF_LOCK = 8'hF5;
  localparam logic [7:0] OFF_CTRL = 8'hFF;
  localparam logic [7:0] WP_TOP = 8'hF0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LOCK_VALID = 8'h1E;
  localparam int CTRL_ATTACH_BIT = 0;
  localparam int CTRL_SOFT_RST_BIT = 1;
  localparam int CTRL_PD_BIT = 2;
  // ****************************************************************
  // Owner field codes
  // ****************************************************************
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_HOST_A = 4'h1;
  localparam logic [3:0] CODE_HOST_B = 4'h2;
  localparam logic [1:0] OWNER_NONE = 2'h0;
  localparam logic [1:0] OWNER_HOST_A = 2'h1;
  localparam logic [1:0] OWNER_HOST_B = 2'h2;
  // ****************************************************************
  // Memory bus
  // ****************************************************************
  localparam logic [6:0] EEPROM_ADDR = 7'h50;
  localparam logic [7:0] WORD_ADDR_START = 8'h00;
  localparam logic [7:0] LAST_WORD = 8'hFF;
  localparam logic [8:0] WORD_COUNT = 9'h100;
  localparam int LINK_CLK_NS = 125;
  localparam int BIT_RATE_KBPS = 100;
  localparam int BIT_NS = 1000000 / BIT_RATE_KBPS;
  localparam int QUARTER_CYC = BIT_NS / LINK_CLK_NS / 4;
  localparam logic [4:0] QUARTER_LAST = 5'(QUARTER_CYC - 1);
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] BOOT_WAIT_CYC = 2'h3;
  typedef enum logic [4:0] {
    L_IDLE = 5'b00001,
    L_START = 5'b00010,
    L_BYTE = 5'b00100,
    L_STOP = 5'b01000,
    L_DONE = 5'b10000
  } link_state_t;
  typedef enum logic [3:0] {
    STEP_ADDR_WR = 4'b0001,
    STEP_WORD = 4'b0010,
    STEP_ADDR_RD = 4'b0100,
    STEP_READ = 4'b1000
  } step_t;
endpackage
`default_nettype wire

/* File: port_ownership_config_loader.sv */
// Port ownership register store with serial memory configuration loader
//
// Operation
// - Upper nibble selects downstream port 4 owner
// - Codes three to fifteen act as host a
// - Lower nibble selects port 3, same coding
// - Owner registers 5/6 and 7 read zero
// - Locked port keeps owner, unlocked may switch
// - Lock bits 7:5 and 0 read zero
// - Power-down bit stops interface after access
// - Power-down bit sticks until pin reset
// - Soft reset restores defaults, clears itself
// - After attach soft reset spares protected registers
// - Attach bit signals attach, protects 00h-F0h
// - Attach bit sticks until pin reset
// - Owner and lock registers writable after attach
// - Load memory first, then attach upstream
// - Loader never writes to the memory
// - Read only when eeprom_select is high at boot; use whatever values arrive
// - Standard-mode rate, 7-bit addressing, no extensions
// - Master drives clock, START and STOP
// - Only sequential read protocol is used
// - Memory answers fixed target address 1010000
`timescale 1ns/1ps
`default_nettype none
module port_ownership_config_loader
  import hub_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic eeprom_select,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [1:0] owner_port3,
  output logic [1:0] owner_port4,
  output logic [3:0] port_lock,
  output logic usb_attach,
  output logic serial_if_powerdown,
  output logic load_busy,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [1:0] decode_owner(input logic [3:0] code);
    logic [1:0] r;
    r = OWNER_HOST_A;
    if (code == CODE_NONE) r = OWNER_NONE;
    else if (code == CODE_HOST_B) r = OWNER_HOST_B;
    return r;
  endfunction

  function automatic logic [7:0] filter_write(input logic [7:0] a,
      input logic [7:0] d, input logic [7:0] old, input logic [7:0] lock);
    logic [7:0] r;
    r = d;
    if (a == OFF_OWNER_5_6 || a == OFF_OWNER_7) r = REG_RESET;
    else if (a == OFF_LOCK) r = d & LOCK_VALID;
    else if (a == OFF_OWNER_3_4) begin
      r[7:4] = lock[4] ? old[7:4] : d[7:4];
      r[3:0] = lock[3] ? old[3:0] : d[3:0];
    end else if (a == OFF_OWNER_1_2) begin
      r[7:4] = lock[2] ? old[7:4] : d[7:4];
      r[3:0] = lock[1] ? old[3:0] : d[3:0];
    end
    return r;
  endfunction

  // ****************************************************************
  // System domain declarations
  // ****************************************************************
  logic [7:0] mem [0:255];
  logic sel_meta, sel_sync;
  logic bt_meta, bt_sync, bt_prev;
  logic [1:0] boot_cnt;
  logic boot_done, req_tgl, load_used, soft_rst;
  logic [8:0] load_idx;
  logic bus_ok, wr_hit, ctrl_wr, byte_new, load_last;
  // Link domain signals read across
  logic byte_tgl;
  logic [7:0] hold_byte;

  assign bus_ok = !serial_if_powerdown && !load_busy;
  assign wr_hit = reg_wr && bus_ok;
  assign ctrl_wr = wr_hit && reg_addr == OFF_CTRL;
  assign byte_new = bt_sync ^ bt_prev;
  assign load_last = load_idx == WORD_COUNT - 9'h001;

  // ****************************************************************
  // Crossings into the system domain
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
      bt_meta <= 1'b0;
      bt_sync <= 1'b0;
      bt_prev <= 1'b0;
    end else begin
      sel_meta <= eeprom_select;
      sel_sync <= sel_meta;
      bt_meta <= byte_tgl;
      bt_sync <= bt_meta;
      bt_prev <= bt_sync;
    end
  end

  // ****************************************************************
  // Boot and load sequencing
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_cnt <= 2'h0;
      boot_done <= 1'b0;
      req_tgl <= 1'b0;
      load_busy <= 1'b0;
      load_used <= 1'b0;
      load_idx <= 9'h000;
    end else begin
      if (!boot_done) begin
        if (boot_cnt == BOOT_WAIT_CYC) begin
          boot_done <= 1'b1;
          if (sel_sync) begin
            req_tgl <= ~req_tgl;
            load_busy <= 1'b1;
            load_used <= 1'b1;
          end
        end else begin
          boot_cnt <= boot_cnt + 2'h1;
        end
      end
      if (load_busy && byte_new) begin
        load_idx <= load_idx + 9'h001;
        if (load_last) load_busy <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control and status bits
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_if_powerdown <= 1'b0;
      usb_attach <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= ctrl_wr && reg_wdata[CTRL_SOFT_RST_BIT];
      if (ctrl_wr && reg_wdata[CTRL_PD_BIT])
        serial_if_powerdown <= 1'b1;
      if (ctrl_wr && reg_wdata[CTRL_ATTACH_BIT])
        usb_attach <= 1'b1;
      if (load_busy && byte_new && load_last)
        usb_attach <= 1'b1;
    end
  end

  // ****************************************************************
  // Register memory
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) mem[i] <= REG_RESET;
    end else if (soft_rst) begin
      for (int i = 0; i < 256; i++)
        if (!(usb_attach && i <= int'(WP_TOP)))
          mem[i] <= REG_RESET;
    end else if (load_busy && byte_new) begin
      if (load_idx[7:0] != OFF_CTRL)
        mem[load_idx[7:0]] <= filter_write(load_idx[7:0], hold_byte,
            mem[load_idx[7:0]], REG_RESET);
    end else if (wr_hit && reg_addr != OFF_CTRL) begin
      if (!(usb_attach && reg_addr <= WP_TOP))
        mem[reg_addr] <= filter_write(reg_addr, reg_wdata,
            mem[reg_addr], mem[OFF_LOCK]);
    end
  end

  // ****************************************************************
  // Read port and decoded outputs
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd && bus_ok) begin
      if (reg_addr == OFF_CTRL)
        reg_rdata <= {5'h00, serial_if_powerdown, soft_rst, usb_attach};
      else
        reg_rdata <= mem[reg_addr];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      owner_port3 <= OWNER_NONE;
      owner_port4 <= OWNER_NONE;
      port_lock <= 4'h0;
    end else begin
      owner_port3 <= decode_owner(mem[OFF_OWNER_3_4][3:0]);
      owner_port4 <= decode_owner(mem[OFF_OWNER_3_4][7:4]);
      port_lock <= mem[OFF_LOCK][4:1];
    end
  end

  // ****************************************************************
  // Link domain: reset and request crossing
  // ****************************************************************
  logic lrst_meta, link_rst;
  logic req_meta, req_sync, req_prev, sda_meta, sda_sync;
  link_state_t state;
  step_t step;
  logic [4:0] qcnt;
  logic [1:0] quarter;
  logic [3:0] bitn;
  logic [8:0] shreg;
  logic [7:0] rxbyte;
  logic [8:0] rd_cnt;
  logic qend, lend, next_scl_oe, next_sda_oe;

  always_ff @(posedge link_clk) begin
    lrst_meta <= rst;
    link_rst <= lrst_meta;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_prev <= 1'b0;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      req_prev <= req_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
    end
  end

  // ****************************************************************
  // Link domain: bit timing at the standard rate
  // ****************************************************************
  assign qend = qcnt == QUARTER_LAST;
  assign lend = qend && quarter == 2'h3;

  always_ff @(posedge link_clk) begin
    if (link_rst || state == L_IDLE || state == L_DONE) begin
      qcnt <= 5'h00;
      quarter <= 2'h0;
    end else if (qend) begin
      qcnt <= 5'h00;
      quarter <= quarter + 2'h1;
    end else begin
      qcnt <= qcnt + 5'h01;
    end
  end

  // ****************************************************************
  // Link domain: transfer sequencer
  // ****************************************************************
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state <= L_IDLE;
      step <= STEP_ADDR_WR;
      bitn <= 4'h0;
      shreg <= 9'h1FF;
      rxbyte <= 8'h00;
      rd_cnt <= 9'h000;
      hold_byte <= 8'h00;
      byte_tgl <= 1'b0;
    end else begin
      unique case (state)
        L_IDLE: begin
          if (req_sync ^ req_prev) begin
            state <= L_START;
            step <= STEP_ADDR_WR;
            rd_cnt <= 9'h000;
          end
        end
        L_START: begin
          if (lend) begin
            state <= L_BYTE;
            bitn <= 4'h0;
            if (step == STEP_ADDR_RD)
              shreg <= {EEPROM_ADDR, 1'b1, 1'b1};
            else
              shreg <= {EEPROM_ADDR, 1'b0, 1'b1};
          end
        end
        L_BYTE: begin
          if (qend && quarter == 2'h2 && bitn != ACK_BIT)
            rxbyte <= {rxbyte[6:0], sda_sync};
          if (lend && bitn != ACK_BIT) begin
            bitn <= bitn + 4'h1;
            shreg <= {shreg[7:0], 1'b1};
          end else if (lend) begin
            bitn <= 4'h0;
            unique case (step)
              STEP_ADDR_WR: begin
                step <= STEP_WORD;
                shreg <= {WORD_ADDR_START, 1'b1};
              end
              STEP_WORD: begin
                step <= STEP_ADDR_RD;
                state <= L_START;
              end
              STEP_ADDR_RD: begin
                step <= STEP_READ;
                shreg <= {8'hFF, 1'b0};
              end
              STEP_READ: begin
                hold_byte <= rxbyte;
                byte_tgl <= ~byte_tgl;
                rd_cnt <= rd_cnt + 9'h001;
                if (rd_cnt == WORD_COUNT - 9'h001) state <= L_STOP;
                else if (rd_cnt == WORD_COUNT - 9'h002)
                  shreg <= {8'hFF, 1'b1};
                else shreg <= {8'hFF, 1'b0};
              end
            endcase
          end
        end
        L_STOP: begin
          if (lend) state <= L_DONE;
        end
        L_DONE: begin
          state <= L_DONE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Link domain: open-drain pin drive
  // ****************************************************************
  always_comb begin
    next_scl_oe = 1'b0;
    next_sda_oe = 1'b0;
    unique case (state)
      L_START: begin
        next_scl_oe = quarter == 2'h0 || quarter == 2'h3;
        next_sda_oe = quarter[1];
      end
      L_BYTE: begin
        next_scl_oe = !quarter[1];
        // Data moves one cycle after clock falls, never with it
        next_sda_oe = (quarter == 2'h0 && qcnt == 5'h00) ? sda_oe
            : !shreg[8];
      end
      L_STOP: begin
        next_scl_oe = quarter == 2'h0;
        next_sda_oe = (quarter == 2'h0 && qcnt == 5'h00) ? sda_oe
            : !quarter[1];
      end
      L_IDLE, L_DONE: begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_soft_req;
    ctrl_wr && reg_wdata[CTRL_SOFT_RST_BIT];
  endsequence

  sequence s_owner_write;
    wr_hit && reg_addr == OFF_OWNER_3_4;
  endsequence

  a_owner4_decode: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> owner_port4 == decode_owner($past(mem[OFF_OWNER_3_4][7:4])))
    else $error("port 4 owner mismatch");
  a_owner_reserved_map: assert property (@(posedge sys_clk)
    disable iff (rst) mem[OFF_OWNER_3_4][3:0] > CODE_HOST_B
    |=> owner_port3 == OWNER_HOST_A)
    else $error("reserved owner code not host a");
  a_lock_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && bus_ok && reg_addr == OFF_LOCK
    |=> reg_rdata[0] == 1'b0 && reg_rdata[7:5] == 3'h0)
    else $error("lock reserved bits not zero");
  a_locked_port_kept: assert property (@(posedge sys_clk)
    disable iff (rst) s_owner_write and mem[OFF_LOCK][4] && !soft_rst
    && !load_busy |=> $stable(mem[OFF_OWNER_3_4][7:4]))
    else $error("locked port reassigned");
  a_runtime_owner: assert property (@(posedge sys_clk) disable iff (rst)
    s_owner_write and usb_attach && mem[OFF_LOCK][4:3] == 2'h0 && !soft_rst
    |=> mem[OFF_OWNER_3_4] == $past(reg_wdata))
    else $error("owner write lost after attach");
  a_powerdown_write: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_wr && reg_wdata[CTRL_PD_BIT] |=> serial_if_powerdown ##1
    serial_if_powerdown)
    else $error("power-down did not take");
  a_powerdown_sticky: assert property (@(posedge sys_clk)
    disable iff (rst) serial_if_powerdown |=> serial_if_powerdown)
    else $error("power-down cleared without reset");
  a_attach_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    usb_attach |=> usb_attach)
    else $error("attach cleared without reset");
  a_protect_low: assert property (@(posedge sys_clk) disable iff (rst)
    wr_hit && usb_attach && reg_addr <= WP_TOP |=> $stable(mem[8'h00])
    || $past(reg_addr) != 8'h00)
    else $error("protected register written");
  a_soft_reset_clear: assert property (@(posedge sys_clk)
    disable iff (rst) s_soft_req ##1 1'b1 |=> mem[OFF_OWNER_3_4] == REG_RESET
    && !soft_rst)
    else $error("soft reset did not restore");
  a_soft_reset_keep: assert property (@(posedge sys_clk) disable iff (rst)
    s_soft_req ##1 usb_attach |=> $stable(mem[8'h00]))
    else $error("soft reset hit protected word");
  a_attach_after_load: assert property (@(posedge sys_clk)
    disable iff (rst) $rose(usb_attach) && load_used
    |-> load_idx == WORD_COUNT || $past(ctrl_wr))
    else $error("attach before load finished");
  a_target_addr: assert property (@(posedge link_clk) disable iff (link_rst)
    state == L_START && lend |=> shreg[8:2] == EEPROM_ADDR)
    else $error("wrong target address");
  a_start_shape: assert property (@(posedge link_clk)
    disable iff (link_rst) state == L_START && quarter == 2'h2
    |=> !scl_oe)
    else $error("clock held low in start");
endmodule // port_ownership_config_loader
`default_nettype wire

/* File: eeprom_model.sv */
// Behavioural two-wire configuration memory, 256 words of 8 bits
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] rx_log [0:7];
  logic rd;
  logic sel;
  int cnt;
  int nb;
  int n_rx;
  int n_wr_data;
  int bit_ns;
  time last_rise;
  initial begin
    pull = 1'h0;
    rd = 1'h0;
    sel = 1'h0;
    sh = 8'h00;
    ptr = 8'h00;
    cnt = 0;
    nb = 0;
    n_rx = 0;
    n_wr_data = 0;
    bit_ns = 0;
    last_rise = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  // ****************************************************************
  // Bus conditions and bit engine
  // ****************************************************************
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
      nb = 0;
      rd = 1'h0;
    end
  end
  always @(posedge sda) begin
    if (scl) sel = 1'h0;
  end
  always @(posedge scl) begin
    bit_ns = int'($time - last_rise);
    last_rise = $time;
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
    if (cnt == 8 && !(rd && nb >= 1)) begin
      if (n_rx < 8) rx_log[n_rx] = sh;
      n_rx = n_rx + 1;
      if (nb == 0) begin
        sel = (sh[7:1] == 7'h50);
        rd = sh[0];
      end else if (nb == 1) ptr = sh;
      else n_wr_data = n_wr_data + 1;
    end
    if (cnt == 9) begin
      if (rd && nb >= 1) ptr = ptr + 8'h01;
      cnt = 0;
      nb = nb + 1;
    end
  end
  // Acknowledge own address, then shift data out on the low phase
  always @(negedge scl) begin
    if (sel && cnt == 8 && !(rd && nb >= 1)) pull = 1'h1;
    else if (sel && rd && nb >= 1 && cnt < 8) pull = ~mem[ptr][3'(7 - cnt)];
    else pull = 1'h0;
  end
endmodule // eeprom_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the port ownership store and loader
`timescale 1ns/1ps
`default_nettype none
module tb
  import hub_cfg_pkg::*;
;
  logic sys_clk, rst, link_clk, eeprom_select, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [1:0] owner_port3, owner_port4;
  logic [3:0] port_lock;
  logic usb_attach, serial_if_powerdown, load_busy;
  logic scl_o, scl_oe, sda_o, sda_oe, mem_pull;
  wire scl_w;
  wire sda_w;
  int n_fail, n_checks, cycles;
  // ****************************************************************
  // Open-drain wires with pull-ups
  // ****************************************************************
  assign scl_w = scl_oe ? 1'h0 : 1'h1;
  assign sda_w = (sda_oe || mem_pull) ? 1'h0 : 1'h1;
  port_ownership_config_loader dut_u (.sys_clk(sys_clk), .rst(rst),
    .link_clk(link_clk), .eeprom_select(eeprom_select), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .owner_port3(owner_port3),
    .owner_port4(owner_port4), .port_lock(port_lock),
    .usb_attach(usb_attach), .serial_if_powerdown(serial_if_powerdown),
    .load_busy(load_busy), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe));
  eeprom_model mem_u (.scl(scl_w), .sda(sda_w), .pull(mem_pull));
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    link_clk = 1'h0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [1:0] own(input logic [3:0] c);
    return (c == CODE_NONE) ? OWNER_NONE : (c == CODE_HOST_B) ?
      OWNER_HOST_B : OWNER_HOST_A;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'h0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    reg_rd = 1'h1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'h0;
    rd_val = reg_rdata;
  endtask
  task automatic do_reset();
    @(negedge sys_clk);
    rst = 1'h1;
    repeat (80) @(negedge sys_clk);
    rst = 1'h0;
    repeat (8) @(negedge sys_clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults();
    logic [7:0] offs [5] = '{OFF_OWNER_3_4, OFF_OWNER_5_6, OFF_OWNER_7,
      OFF_LOCK, OFF_CTRL};
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset value", rd_val, REG_RESET);
    end
    $display("test defaults done");
  endtask
  task automatic t_owner();
    for (int c = 0; c < 16; c++) begin
      wr(OFF_OWNER_3_4, {4'(c), 4'(15 - c)});
      chk("port4 owner", 8'(owner_port4), 8'(own(4'(c))));
      chk("port3 owner", 8'(owner_port3), 8'(own(4'(15 - c))));
    end
    $display("test owner codes done");
  endtask
  task automatic t_lock();
    wr(OFF_LOCK, 8'hFF);
    rd(OFF_LOCK);
    chk("lock mask", rd_val, 8'h1E);
    chk("port lock", 8'(port_lock), 8'h0F);
    wr(OFF_OWNER_3_4, 8'h22);
    chk("locked port4", 8'(owner_port4), 8'h01);
    chk("locked port3", 8'(owner_port3), 8'h00);
    wr(OFF_LOCK, 8'h10);
    wr(OFF_OWNER_3_4, 8'h22);
    chk("locked port4", 8'(owner_port4), 8'h01);
    chk("free port3", 8'(owner_port3), 8'h02);
    wr(OFF_OWNER_5_6, 8'hFF);
    wr(OFF_OWNER_7, 8'hFF);
    rd(OFF_OWNER_5_6);
    chk("owner 5/6", rd_val, 8'h00);
    rd(OFF_OWNER_7);
    chk("owner 7", rd_val, 8'h00);
    $display("test lock done");
  endtask
  task automatic t_soft_reset();
    wr(WP_TOP, 8'h5A);
    wr(OFF_CTRL, 8'h02);
    rd(OFF_OWNER_3_4);
    chk("owner after soft reset", rd_val, 8'h00);
    rd(OFF_LOCK);
    chk("lock after soft reset", rd_val, 8'h00);
    rd(WP_TOP);
    chk("memory after soft reset", rd_val, 8'h00);
    rd(OFF_CTRL);
    chk("soft reset bit", rd_val, 8'h00);
    $display("test soft reset done");
  endtask
  task automatic t_attach();
    wr(WP_TOP, 8'h5A);
    wr(OFF_CTRL, 8'h01);
    chk("attach", 8'(usb_attach), 8'h01);
    wr(WP_TOP, 8'hA5);
    rd(WP_TOP);
    chk("protected byte", rd_val, 8'h5A);
    wr(OFF_CTRL, 8'h00);
    rd(OFF_CTRL);
    chk("control after clear try", rd_val, 8'h01);
    wr(OFF_OWNER_3_4, 8'h21);
    chk("run-time port3", 8'(owner_port3), 8'h01);
    chk("run-time port4", 8'(owner_port4), 8'h02);
    wr(OFF_LOCK, 8'h02);
    wr(OFF_CTRL, 8'h03);
    rd(WP_TOP);
    chk("spared byte", rd_val, 8'h5A);
    rd(OFF_OWNER_3_4);
    chk("unprotected owner", rd_val, 8'h00);
    chk("unprotected lock", 8'(port_lock), 8'h00);
    chk("attach kept", 8'(usb_attach), 8'h01);
    $display("test attach done");
  endtask
  task automatic t_powerdown();
    wr(OFF_CTRL, 8'h04);
    chk("powerdown", 8'(serial_if_powerdown), 8'h01);
    wr(OFF_OWNER_3_4, 8'h22);
    chk("write while down", 8'(owner_port3), 8'h00);
    do_reset();
    chk("powerdown after pin reset", 8'(serial_if_powerdown), 8'h00);
    chk("attach after pin reset", 8'(usb_attach), 8'h00);
    rd(OFF_CTRL);
    chk("control after pin reset", rd_val, 8'h00);
    $display("test powerdown done");
  endtask
  task automatic t_load();
    eeprom_select = 1'h1;
    do_reset();
    chk("loading", 8'(load_busy), 8'h01);
    for (int i = 0; i < 70000 && mem_u.n_rx < 3; i++) @(negedge sys_clk);
    chk("address write", mem_u.rx_log[0], {EEPROM_ADDR, 1'h0});
    chk("start word", mem_u.rx_log[1], WORD_ADDR_START);
    chk("address read", mem_u.rx_log[2], {EEPROM_ADDR, 1'h1});
    chk("data writes", 8'(mem_u.n_wr_data), 8'h00);
    chk("bit period", 8'(mem_u.bit_ns / 100), 8'h64);
    chk("no early attach", 8'(usb_attach), 8'h00);
    $display("test load done");
  endtask
  initial begin
    sys_clk = 1'h0;
    rst = 1'h1;
    eeprom_select = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    do_reset();
    t_defaults();
    t_owner();
    t_lock();
    t_soft_reset();
    t_attach();
    t_powerdown();
    t_load();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
